// File: ddc_link_pkg.sv
/*
 * Shared constants for the down-converter and serial link control bank.
 * Assumes byte-wide registers at their printed offsets on a plain port.
 */
package ddc_link_pkg;
    localparam int ADDR_W = 10;
    localparam logic [9:0] OFS_DDC_CTRL = 10'h200;
    localparam logic [9:0] OFS_LINK_A = 10'h201;
    localparam logic [9:0] OFS_LINK_B = 10'h202;
    localparam logic [9:0] OFS_LINK_DID = 10'h203;
    localparam logic [9:0] OFS_LINK_C = 10'h204;
    localparam logic [7:0] RST_DDC_CTRL = 8'h10;
    localparam logic [7:0] RST_LINK_A = 8'h0f;
    localparam logic [7:0] RST_LINK_B = 8'h00;
    localparam logic [7:0] RST_LINK_DID = 8'h00;
    localparam logic [7:0] RST_LINK_C = 8'h00;
    // Field positions
    localparam int FMT_BIT = 5;
    localparam int BOOST_BIT = 4;
    localparam int SCR_BIT = 7;
    localparam int DDR_BIT = 1;
    localparam int EN_BIT = 0;
    localparam int PLL54_BIT = 7;
    localparam int SYNCSEL_BIT = 6;
    // Decimation mode codes, the transport test pattern code and the zero byte
    localparam logic [3:0] DECIMATION_MODE_BYPASS = 4'h0;
    localparam logic [3:0] DECIMATION_MODE_DEC4 = 4'h2;
    localparam logic [3:0] DECIMATION_MODE_DEC32 = 4'h7;
    localparam logic [3:0] TEST_TRANSPORT = 4'h5;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// File: ddc_link_if.sv
/*
 * Carrier between the control bank (device end) and its software master.
 * Assumes one clock; both ends share mclk and reset_n.
 */
`timescale 1ns/1ps
interface ddc_link_if;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// File: ddc_link_regs.sv
/*
 * Device end: DDC and serial link control registers with decoded controls.
 * Assumes the master keeps the enable-low discipline for reconfiguration.
 */
`timescale 1ns/1ps
module ddc_link_regs
    import ddc_link_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    ddc_link_if.dev bus,
    // Decoded controls
    output logic signed_output,
    output logic boost_6db,
    output logic [3:0] decimation_mode,
    output logic mode_reserved,
    output logic scrambler_enable,
    output logic [4:0] frames_per_multiframe_m1,
    output logic double_rate,
    output logic link_reset_n,
    output logic serializer_power,
    output logic link_clock_enable,
    output logic [3:0] link_test_pattern,
    output logic transport_pattern,
    output logic [7:0] link_device_identifier,
    output logic sync_input_select,
    output logic five_fourths_pll_enable,
    output logic [1:0] frame_char_select
);
    logic [7:0] ddc_ctrl_ff;
    logic [7:0] link_a_ff;
    logic [7:0] link_b_ff;
    logic [7:0] did_ff;
    logic [7:0] link_c_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // Writes are accepted at any time; ordering against enable is software's job
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ddc_ctrl_ff <= RST_DDC_CTRL;
            link_a_ff <= RST_LINK_A;
            link_b_ff <= RST_LINK_B;
            did_ff <= RST_LINK_DID;
            link_c_ff <= RST_LINK_C;
        end else if (bus.wr) begin
            case (bus.addr)
                OFS_DDC_CTRL: ddc_ctrl_ff <= bus.wdata;
                OFS_LINK_A: link_a_ff <= bus.wdata;
                OFS_LINK_B: link_b_ff <= bus.wdata;
                OFS_LINK_DID: did_ff <= bus.wdata;
                OFS_LINK_C: link_c_ff <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (bus.addr)
            OFS_DDC_CTRL: nxt_rdata = ddc_ctrl_ff;
            OFS_LINK_A: nxt_rdata = link_a_ff;
            OFS_LINK_B: nxt_rdata = link_b_ff;
            OFS_LINK_DID: nxt_rdata = did_ff;
            OFS_LINK_C: nxt_rdata = link_c_ff;
            default: nxt_rdata = BYTE_ZERO;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= BYTE_ZERO;
        end else if (bus.rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= BYTE_ZERO;
        end
    end
    assign bus.rdata = rdata_ff;

    // Decimating modes force signed regardless of format bit
    assign signed_output = (decimation_mode == DECIMATION_MODE_BYPASS) ?
        ddc_ctrl_ff[FMT_BIT] : 1'b1;
    assign boost_6db = ddc_ctrl_ff[BOOST_BIT];
    assign decimation_mode = ddc_ctrl_ff[3:0];
    assign mode_reserved = (decimation_mode != DECIMATION_MODE_BYPASS) &&
        ((decimation_mode < DECIMATION_MODE_DEC4) || (decimation_mode > DECIMATION_MODE_DEC32));
    assign scrambler_enable = link_a_ff[SCR_BIT];
    assign frames_per_multiframe_m1 = link_a_ff[6:2];
    assign double_rate = link_a_ff[DDR_BIT];
    // Disabled link: reset, serializers off, clocks gated
    assign link_reset_n = link_a_ff[EN_BIT];
    assign serializer_power = link_a_ff[EN_BIT];
    assign link_clock_enable = link_a_ff[EN_BIT];
    assign link_test_pattern = link_b_ff[3:0];
    assign transport_pattern = (link_b_ff[3:0] == TEST_TRANSPORT);
    assign link_device_identifier = did_ff;
    assign sync_input_select = link_b_ff[SYNCSEL_BIT];
    assign five_fourths_pll_enable = link_b_ff[PLL54_BIT];
    assign frame_char_select = link_c_ff[1:0];
endmodule

// File: ddc_link_ctl.sv
/*
 * Software end: turns user requests into register strobes, and keeps the
 * enable-low discipline: any write to a guarded register first clears the
 * enable, then writes, then restores the enable if it was on, or for control A if the new byte sets it.
 * Assumes one request at a time; busy falls one edge before the shadow takes the enable restore, so a guarded write waits one more cycle.
 */
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module ddc_link_ctl
    import ddc_link_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    ddc_link_if.ctl bus,
    // User side
    input wire logic req_wr,
    input wire logic req_rd,
    input wire logic [9:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic busy,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DISABLE = 3'b001,
        ST_WRITE = 3'b010,
        ST_ENABLE = 3'b011,
        ST_READ = 3'b100
    } state_t;

    state_t state_ff;
    logic [9:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] link_a_ff;
    logic restore_ff;
    logic [9:0] bus_addr_ff;
    logic [7:0] bus_wdata_ff;
    logic bus_wr_ff;
    logic bus_rd_ff;
    logic rd_wait_ff;
    logic rd_valid_ff;
    logic [7:0] rd_data_ff;
    logic guarded;

    assign guarded = (req_addr >= OFS_DDC_CTRL) && (req_addr <= OFS_LINK_C);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            addr_ff <= '0;
            wdata_ff <= BYTE_ZERO;
            restore_ff <= 1'b0;
            bus_addr_ff <= '0;
            bus_wdata_ff <= BYTE_ZERO;
            bus_wr_ff <= 1'b0;
            bus_rd_ff <= 1'b0;
        end else begin
            bus_wr_ff <= 1'b0;
            bus_rd_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    addr_ff <= req_addr;
                    wdata_ff <= req_wdata;
                    if (req_wr && guarded) begin
                        // Clear enable first
                        restore_ff <= link_a_ff[EN_BIT];
                        bus_addr_ff <= OFS_LINK_A;
                        bus_wdata_ff <= link_a_ff & ~(8'h01 << EN_BIT);
                        bus_wr_ff <= 1'b1;
                        state_ff <= ST_WRITE;
                    end else if (req_wr) begin
                        bus_addr_ff <= req_addr;
                        bus_wdata_ff <= req_wdata;
                        bus_wr_ff <= 1'b1;
                    end else if (req_rd) begin
                        bus_addr_ff <= req_addr;
                        bus_rd_ff <= 1'b1;
                        state_ff <= ST_READ;
                    end
                end
                ST_WRITE: begin
                    bus_addr_ff <= addr_ff;
                    // A write to control A itself keeps enable low for now
                    bus_wdata_ff <= (addr_ff == OFS_LINK_A) ?
                        (wdata_ff & ~(8'h01 << EN_BIT)) : wdata_ff;
                    bus_wr_ff <= 1'b1;
                    if (addr_ff == OFS_LINK_A) begin
                        restore_ff <= wdata_ff[EN_BIT];
                    end
                    state_ff <= ST_ENABLE;
                end
                ST_ENABLE: begin
                    if (restore_ff) begin
                        bus_addr_ff <= OFS_LINK_A;
                        // Shadow lags the control A write by one edge, so use the new byte
                        bus_wdata_ff <= ((addr_ff == OFS_LINK_A) ? wdata_ff : link_a_ff) |
                            (8'h01 << EN_BIT);
                        bus_wr_ff <= 1'b1;
                    end
                    state_ff <= ST_IDLE;
                end
                ST_READ: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Shadow of control A so enable can be cleared and restored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            link_a_ff <= RST_LINK_A;
        end else if (bus_wr_ff && (bus_addr_ff == OFS_LINK_A)) begin
            link_a_ff <= bus_wdata_ff;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_wait_ff <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= BYTE_ZERO;
        end else begin
            // Read data stands only in the cycle after the strobe
            rd_wait_ff <= bus_rd_ff;
            rd_valid_ff <= rd_wait_ff;
            if (rd_wait_ff) begin
                rd_data_ff <= bus.rdata;
            end
        end
    end

    assign bus.addr = bus_addr_ff;
    assign bus.wdata = bus_wdata_ff;
    assign bus.wr = bus_wr_ff;
    assign bus.rd = bus_rd_ff;
    assign busy = (state_ff != ST_IDLE);
    assign rd_valid = rd_valid_ff;
    assign rd_data = rd_data_ff;
endmodule

// File: ddc_link_chk.sv
/* Checker on the register port between the two ends.
   Assumes one clock domain and the plain interface signals as inputs. */
`timescale 1ns/1ps
module ddc_link_chk
    import ddc_link_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Port signals
    input wire logic [9:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata
);
    logic [7:0] mirror_ff [5];
    logic [7:0] mirror_rd;
    logic mapped;
    assign mapped = addr >= OFS_DDC_CTRL && addr <= OFS_LINK_C;
    assign mirror_rd = mapped ? mirror_ff[3'(addr - OFS_DDC_CTRL)] : 8'h00;
    // Reserved bits are mirrored too, they store what was written
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mirror_ff <= '{8'h10, 8'h0f, 8'h00, 8'h00, 8'h00};
        end else if (wr && mapped) begin
            mirror_ff[3'(addr - OFS_DDC_CTRL)] <= wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property readback(logic [9:0] ofs);
        rd && addr == ofs |=> rdata == $past(mirror_rd);
    endproperty
    // Guarded write must come right after a write that clears the enable
    property guarded(logic [9:0] ofs);
        wr && addr == ofs |-> $past(wr) && $past(addr) == OFS_LINK_A && !$past(wdata[EN_BIT]);
    endproperty
    property clear_then_write;
        wr && addr == OFS_LINK_A && !wdata[EN_BIT] && !$past(wr) |=> wr && mapped;
    endproperty
    a_mode_readback: assert property (readback(OFS_DDC_CTRL))
        else $error("control byte read back wrong");
    a_ctl_a_readback: assert property (readback(OFS_LINK_A))
        else $error("link control a read back wrong");
    a_ctl_b_readback: assert property (readback(OFS_LINK_B))
        else $error("link control b read back wrong");
    a_ident_readback: assert property (readback(OFS_LINK_DID))
        else $error("identifier read back wrong");
    a_mode_guard: assert property (guarded(OFS_DDC_CTRL))
        else $error("mode written with link enabled");
    a_ctl_b_guard: assert property (guarded(OFS_LINK_B))
        else $error("link control b written with link enabled");
    a_ident_guard: assert property (guarded(OFS_LINK_DID))
        else $error("identifier written with link enabled");
    a_clear_then_write: assert property (clear_then_write)
        else $error("enable clear not followed by write");
    c_guarded: cover property (wr && addr == OFS_LINK_A ##1 wr && addr == OFS_LINK_B);
    c_read: cover property (rd ##1 rdata != 8'h00);
    c_unmapped: cover property (rd && !mapped);
endmodule

// File: ddc_serial_link_control_regs_tb.sv
/* Bench for both ends joined over the register port.
   Assumes the control end is the only master of the device end. */
`timescale 1ns/1ps
module ddc_serial_link_control_regs_tb
    import ddc_link_pkg::*;
;
    logic mclk, reset_n, req_wr, req_rd, busy, rd_valid;
    logic [9:0] req_addr;
    logic [7:0] req_wdata, rd_data, link_device_identifier;
    logic signed_output, boost_6db, mode_reserved, scrambler_enable, double_rate;
    logic link_reset_n, serializer_power, link_clock_enable, transport_pattern;
    logic sync_input_select, five_fourths_pll_enable;
    logic [3:0] decimation_mode, link_test_pattern;
    logic [4:0] frames_per_multiframe_m1;
    logic [1:0] frame_char_select;
    int mismatches, checked;
    ddc_link_if link_if ();
    ddc_link_regs ddc_link_regs_inst (.mclk, .reset_n, .bus(link_if.dev), .signed_output,
        .boost_6db, .decimation_mode, .mode_reserved, .scrambler_enable,
        .frames_per_multiframe_m1, .double_rate, .link_reset_n, .serializer_power,
        .link_clock_enable, .link_test_pattern, .transport_pattern, .link_device_identifier,
        .sync_input_select, .five_fourths_pll_enable, .frame_char_select);
    ddc_link_ctl ddc_link_ctl_inst (.mclk, .reset_n, .bus(link_if.ctl), .req_wr, .req_rd,
        .req_addr, .req_wdata, .busy, .rd_valid, .rd_data);
    ddc_link_chk ddc_link_chk_inst (.mclk, .reset_n, .addr(link_if.addr),
        .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata));
    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic strobe(input logic w, input logic [9:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk);
        req_wr <= w;
        req_rd <= !w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge mclk);
        req_wr <= 0;
        req_rd <= 0;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while ((w ? busy !== 0 : rd_valid !== 1) && n < 20);
        if (n >= 20) begin
            mismatches++;
            $display("Error at %0t: no completion", $time);
            tally_and_finish();
        end
    endtask
    // Extra cycle lets the enable restore land before outputs are checked
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        strobe(1, a, d);
        @(posedge mclk);
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        strobe(0, a, 8'h00);
        chk(rd_data, exp);
    endtask
    initial begin
        logic [7:0] rst_v [5];
        rst_v = '{8'h10, 8'h0f, 8'h00, 8'h00, 8'h00};
        {reset_n, req_wr, req_rd, req_addr, req_wdata} = '0;
        mismatches = 0;
        checked = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1;
        for (int i = 0; i < 5; i++) begin
            rd(OFS_DDC_CTRL + 10'(i), rst_v[i]);
        end
        chk(8'({boost_6db, signed_output, double_rate, link_reset_n}), 8'h0b);
        chk(8'(frames_per_multiframe_m1), 8'h03);
        rd(10'h205, 8'h00);
        for (int m = 0; m < 16; m++) begin
            wr(OFS_DDC_CTRL, 8'(m) | 8'h10);
            chk(8'({mode_reserved, signed_output, decimation_mode}),
                8'({m == 1 || m > 7, m != 0, 4'(m)}));
        end
        wr(OFS_DDC_CTRL, 8'he0);
        chk(8'({signed_output, boost_6db, link_reset_n}), 8'h05);
        rd(OFS_DDC_CTRL, 8'he0);
        wr(OFS_LINK_A, 8'h9c);
        chk(8'({scrambler_enable, double_rate, link_reset_n, serializer_power,
            link_clock_enable}), 8'h10);
        chk(8'(frames_per_multiframe_m1), 8'h07);
        for (int m = 0; m < 16; m++) begin
            wr(OFS_LINK_B, 8'({m[0], m[1], 2'b00, 4'(m)}));
            chk(8'({five_fourths_pll_enable, sync_input_select, transport_pattern,
                link_test_pattern}), 8'({m[0], m[1], m == 5, 4'(m)}));
        end
        rd(OFS_LINK_B, 8'hcf);
        wr(OFS_LINK_A, 8'h0f);
        rd(OFS_LINK_A, 8'h0f);
        wr(OFS_LINK_DID, 8'ha5);
        chk(link_device_identifier, 8'ha5);
        chk(8'(link_reset_n), 8'h01);
        rd(OFS_LINK_DID, 8'ha5);
        wr(OFS_LINK_C, 8'hfe);
        chk(8'(frame_char_select), 8'h02);
        rd(OFS_LINK_C, 8'hfe);
        tally_and_finish();
    end
endmodule
